// >>> core/lslt_top.sv
// Status lamp patterns and trigger conditioning for a two-channel logger
`timescale 1ns/10ps
`include "lslt_map.svh"
// Summary of operation
// - Logger traffic gives channel lamp short flash
// - Error passive blinks channel, and red error in logger mode
// - Bus off blinks channel and red slowly in logger mode, both steady in interface mode
// - Error frame gives short yellow flash
// - Major error: red, going dark only during the coded yellow flashes
// - Armed: power lamp 90% on, 10% off
// - Actively logging: power lamp flashes
// - Stopped by trigger: power slow 50/50 blink
// - Tool communication: running light over lamps
// - Tool disk activity: error lamp blinks red
// - No disk and no USB in logger mode: all blink slowly
// - No USB communication: rare power flash only
// - Firmware config error: power flash, red steady
// - Trigger fires on the selected edge
// - Trigger pulses under 30 ms are ignored
// - Configurable pulse on the trigger output
// - Lamp pattern set follows operating mode
// - Interface mode: power steady, channel flashes
// - USB seen while logging: stop and close
// - Powered with valid disk: start logging
// - Interface mode waiting: power blinks slowly
module lslt_top
    import lslt_pkg::*;
#(
    parameter int unsigned TICK_CYC = `LSLT_TICK_MS * `LSLT_CLK_KHZ
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic logger_mode,
    input wire logic [1:0] can_rx_evt,
    input wire logic [1:0] can_tx_evt,
    input wire logic [1:0] err_passive,
    input wire logic [1:0] bus_off,
    input wire logic err_frame_evt,
    input wire logic [2:0] major_err_code,
    input wire logic log_armed,
    input wire logic log_active,
    input wire logic log_stopped,
    input wire logic tool_comm,
    input wire logic tool_disk_busy,
    input wire logic disk_missing,
    input wire logic usb_present,
    input wire logic usb_no_comm,
    input wire logic fw_cfg_err,
    input wire logic can_powered,
    input wire logic disk_ready,
    input wire logic trig_edge_rising,
    input wire logic trig_pin_in,
    input wire logic pulse_req,
    input wire logic [7:0] pulse_len_ms,
    output logic trig_fire,
    output logic trig_out_o,
    output logic trig_out_oe,
    output logic log_start,
    output logic log_stop_close,
    output logic logging_on,
    output logic power_status_lamp,
    output logic channel_one_lamp,
    output logic channel_two_lamp,
    output logic err_lamp_red,
    output logic err_lamp_yellow
);
    lslt_if lk ();

    // Time base
    logic [16:0] pre_r;
    logic tick;
    lslt_ms_t ms_r;

    // Short flash timers
    logic [2:0] flash_evt;
    logic [5:0] flash_r [3];
    logic [2:0] flash_on;

    // Lamp selection and drivers
    logic chan_base [2];
    logic [1:0] chan_nxt;
    logic [1:0] chan_r;
    logic pwr_nxt;
    logic pwr_r;
    logic red_nxt;
    logic red_r;
    logic yel_nxt;
    logic yel_r;

    // Pattern waves and indices
    logic w_fast;
    logic w_blink;
    logic w_slow;
    logic w_arm;
    logic w_rare;
    logic code_yel;
    logic [1:0] run_idx;
    logic [3:0] code_slot;
    logic [2:0] code_cnt;
    lslt_err_e err_code;

    // Logging session
    lslt_log_e log_r;
    logic start_r;
    logic stop_r;

    // True while ms phase within a period is below on time
    function automatic logic wave(
        input lslt_ms_t ms,
        input lslt_ms_t per,
        input lslt_ms_t on
    );
        wave = (ms & (per - 13'h0001)) < on;
    endfunction

    // Millisecond prescaler
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pre_r <= 17'h00000;
        end else if (clk_en) begin
            if (tick) begin
                pre_r <= 17'h00000;
            end else begin
                pre_r <= pre_r + 17'h00001;
            end
        end
    end

    assign tick = (pre_r == 17'(TICK_CYC - 1));

    // Free-running pattern phase in ms
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ms_r <= 13'h0000;
        end else if (clk_en && tick) begin
            ms_r <= ms_r + 13'h0001;
        end
    end

    // Pattern waveforms from the shared phase
    always_comb begin
        w_fast = wave(ms_r, `LSLT_FAST_PER, `LSLT_FAST_ON);
        w_blink = wave(ms_r, `LSLT_BLINK_PER, `LSLT_BLINK_ON);
        w_slow = wave(ms_r, `LSLT_SLOW_PER, `LSLT_SLOW_ON);
        w_arm = wave(ms_r, `LSLT_ARM_PER, `LSLT_ARM_ON);
        w_rare = wave(ms_r, `LSLT_RARE_PER, `LSLT_RARE_ON);
    end

    // Running light position, one lamp per step
    assign run_idx = ms_r[`LSLT_RUN_SH+1:`LSLT_RUN_SH];

    // Error code group: flash in even slots while count not reached
    assign code_slot = ms_r[`LSLT_CODE_SH+3:`LSLT_CODE_SH];
    assign err_code = lslt_err_e'(major_err_code);
    // Undefined codes above the last flash as other errors
    assign code_cnt = (err_code > LSLT_ERR_OTHER) ?
        3'(LSLT_ERR_OTHER) : major_err_code;
    assign code_yel = !code_slot[0] &&
        ({1'b0, code_slot[3:1]} < {1'b0, code_cnt});

    // Short flash sources: two channels of traffic and error frames
    assign flash_evt = {err_frame_evt, can_tx_evt | can_rx_evt};

    genvar g;
    // One retriggerable short flash timer per source
    for (g = 0; g < 3; g++) begin : g_flash
        always_ff @(posedge sys_clk) begin
            if (!reset_n) begin
                flash_r[g] <= 6'h00;
            end else if (clk_en) begin
                if (flash_evt[g]) begin
                    flash_r[g] <= `LSLT_SHORT_MS;
                end else if (tick && flash_r[g] != 6'h00) begin
                    flash_r[g] <= flash_r[g] - 6'h01;
                end
            end
        end
        assign flash_on[g] = (flash_r[g] != 6'h00);
    end

    // Per-channel lamp from bus state, then traffic
    for (g = 0; g < 2; g++) begin : g_chan
        always_comb begin
            if (bus_off[g]) begin
                // Logger blinks slowly, interface holds steady
                chan_base[g] = logger_mode ? w_slow : 1'b1;
            end else if (err_passive[g]) begin
                chan_base[g] = w_blink;
            end else begin
                chan_base[g] = flash_on[g];
            end
        end
    end

    // Lamp selection by priority
    always_comb begin
        pwr_nxt = 1'b0;
        chan_nxt = 2'b00;
        red_nxt = 1'b0;
        yel_nxt = 1'b0;
        if (fw_cfg_err) begin
            pwr_nxt = w_fast;
            red_nxt = 1'b1;
        end else if (tool_comm) begin
            // Lamps lit one after another
            pwr_nxt = (run_idx == 2'b00);
            chan_nxt = {run_idx == 2'b10, run_idx == 2'b01};
            red_nxt = (run_idx == 2'b11) ||
                (tool_disk_busy && w_blink);
        end else if (tool_disk_busy && usb_present) begin
            // Host disk work: power on, red blinks
            pwr_nxt = 1'b1;
            red_nxt = w_blink;
        end else if (disk_missing && !usb_present && logger_mode) begin
            // No disk and no host: all lamps slow
            pwr_nxt = w_slow;
            chan_nxt = {w_slow, w_slow};
            red_nxt = w_slow;
        end else if (usb_no_comm) begin
            // Host silent: rare power flash only
            pwr_nxt = w_rare;
        end else if (!logger_mode) begin
            // Interface mode set
            pwr_nxt = usb_present ? 1'b1 : w_slow;
            chan_nxt = {chan_base[1], chan_base[0]};
            red_nxt = |bus_off;
            yel_nxt = flash_on[2] && !(|bus_off);
        end else begin
            // Logger mode: logging status on the power lamp
            if (log_armed) begin
                pwr_nxt = w_arm;
            end else if (log_active) begin
                pwr_nxt = w_fast;
            end else if (log_stopped) begin
                pwr_nxt = w_slow;
            end
            chan_nxt = {chan_base[1], chan_base[0]};
            // Error lamp: major code over bus state over frames
            if (err_code != LSLT_ERR_NONE) begin
                red_nxt = !code_yel;
                yel_nxt = code_yel;
            end else if (|bus_off) begin
                red_nxt = w_slow;
            end else if (|err_passive) begin
                red_nxt = w_blink;
            end else begin
                yel_nxt = flash_on[2];
            end
        end
    end

    // Registered power and channel lamps
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pwr_r <= 1'b0;
            chan_r <= 2'b00;
        end else if (clk_en) begin
            pwr_r <= pwr_nxt;
            chan_r <= chan_nxt;
        end
    end

    // Registered bicolour error lamp
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            red_r <= 1'b0;
            yel_r <= 1'b0;
        end else if (clk_en) begin
            red_r <= red_nxt;
            yel_r <= yel_nxt;
        end
    end

    // Logging session start and orderly stop
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            log_r <= LSLT_LOG_IDLE;
            start_r <= 1'b0;
            stop_r <= 1'b0;
        end else if (clk_en) begin
            start_r <= 1'b0;
            stop_r <= 1'b0;
            case (log_r)
                LSLT_LOG_IDLE: begin
                    if (logger_mode && can_powered && disk_ready &&
                        !usb_present) begin
                        log_r <= LSLT_LOG_RUN;
                        start_r <= 1'b1;
                    end
                end
                LSLT_LOG_RUN: begin
                    if (usb_present) begin
                        log_r <= LSLT_LOG_HOLD;
                        stop_r <= 1'b1;
                    end else if (!can_powered || !logger_mode) begin
                        log_r <= LSLT_LOG_IDLE;
                    end
                end
                LSLT_LOG_HOLD: begin
                    // Wait until the host lets go
                    if (!usb_present) begin
                        log_r <= LSLT_LOG_IDLE;
                    end
                end
                default: begin
                    log_r <= LSLT_LOG_IDLE;
                end
            endcase
        end
    end

    // Trigger conditioner hookup
    assign lk.ce = clk_en;
    assign lk.tick = tick;
    assign lk.edge_rising = trig_edge_rising;
    assign lk.pulse_req = pulse_req;
    assign lk.pulse_len = pulse_len_ms;

    lslt_trig u_trig (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .trig_pin_in(trig_pin_in),
        .trig_out_oe(trig_out_oe),
        .lk(lk.trig)
    );

    // Trigger outputs
    assign trig_fire = lk.fire;
    assign trig_out_o = `LSLT_TRIG_OUT_LVL;

    // Logging session outputs
    assign log_start = start_r;
    assign log_stop_close = stop_r;
    assign logging_on = (log_r == LSLT_LOG_RUN);

    // Lamp outputs
    assign power_status_lamp = pwr_r;
    assign channel_one_lamp = chan_r[0];
    assign channel_two_lamp = chan_r[1];
    assign err_lamp_red = red_r;
    assign err_lamp_yellow = yel_r;
endmodule

// >>> core/lslt_map.svh
// Timing and encoding constants for the status lamp and trigger block
`ifndef LSLT_MAP_SVH
`define LSLT_MAP_SVH

// Clock rate in kHz, so cycles per millisecond
`define LSLT_CLK_KHZ 100000
// Pattern time base, one tick per millisecond
`define LSLT_TICK_MS 1
// Trigger debounce time in ms
`define LSLT_DEBOUNCE_MS 30
// Debounce count in ticks
`define LSLT_DEB_TICKS (`LSLT_DEBOUNCE_MS / `LSLT_TICK_MS)

// Short flash length, 40 ms
`define LSLT_SHORT_MS 6'h28
// Fast flash, 128 ms period, half on
`define LSLT_FAST_PER 13'h0080
`define LSLT_FAST_ON 13'h0040
// Blink, 512 ms period, half on
`define LSLT_BLINK_PER 13'h0200
`define LSLT_BLINK_ON 13'h0100
// Slow blink, 2048 ms period, half on
`define LSLT_SLOW_PER 13'h0800
`define LSLT_SLOW_ON 13'h0400
// Armed pattern, 1024 ms period, 922 ms on
`define LSLT_ARM_PER 13'h0400
`define LSLT_ARM_ON 13'h039A
// Rare flash, 4096 ms period, 64 ms on
`define LSLT_RARE_PER 13'h1000
`define LSLT_RARE_ON 13'h0040
// Running light step, 256 ms per lamp
`define LSLT_RUN_SH 8
// Error code slot, 256 ms per slot, 16 slots
`define LSLT_CODE_SH 8
// Open-drain trigger output level when driven
`define LSLT_TRIG_OUT_LVL 1'b0
// Accepted trigger level after reset (input pulled up)
`define LSLT_TRIG_IDLE 1'b1

`endif

// >>> core/lslt_pkg.sv
// Types for the status lamp and trigger block
package lslt_pkg;

    // Major error code, value equals the yellow flash count
    typedef enum logic [2:0] {
        LSLT_ERR_NONE,
        LSLT_ERR_OVERRUN,
        LSLT_ERR_DISK_FULL,
        LSLT_ERR_CFG_BAD,
        LSLT_ERR_DISK,
        LSLT_ERR_OTHER
    } lslt_err_e;

    // Logging session control states
    typedef enum logic [1:0] {
        LSLT_LOG_IDLE,
        LSLT_LOG_RUN,
        LSLT_LOG_HOLD
    } lslt_log_e;

    typedef logic [12:0] lslt_ms_t;

endpackage

// >>> core/lslt_if.sv
// Carrier between the lamp top and the trigger conditioner
`timescale 1ns/10ps
interface lslt_if;
    logic ce;
    logic tick;
    logic edge_rising;
    logic pulse_req;
    logic [7:0] pulse_len;
    logic fire;

    modport top (
        output ce,
        output tick,
        output edge_rising,
        output pulse_req,
        output pulse_len,
        input fire
    );
    modport trig (
        input ce,
        input tick,
        input edge_rising,
        input pulse_req,
        input pulse_len,
        output fire
    );
endinterface

// >>> core/lslt_trig.sv
// Trigger input debounce, edge select and pulse output
`timescale 1ns/10ps
`include "lslt_map.svh"
module lslt_trig (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic trig_pin_in,
    output logic trig_out_oe,
    lslt_if.trig lk
);
    logic sync1_r;
    logic sync2_r;
    logic lvl_r;
    logic [5:0] deb_r;
    logic fire_r;
    logic [7:0] pulse_r;

    // Two-stage synchroniser on the pin
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sync1_r <= `LSLT_TRIG_IDLE;
            sync2_r <= `LSLT_TRIG_IDLE;
        end else if (lk.ce) begin
            sync1_r <= trig_pin_in;
            sync2_r <= sync1_r;
        end
    end

    // Level must differ for the full debounce time
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            deb_r <= 6'h00;
            lvl_r <= `LSLT_TRIG_IDLE;
            fire_r <= 1'b0;
        end else if (lk.ce) begin
            fire_r <= 1'b0;
            if (sync2_r == lvl_r) begin
                deb_r <= 6'h00;
            end else if (lk.tick) begin
                if (deb_r == 6'(`LSLT_DEB_TICKS - 1)) begin
                    deb_r <= 6'h00;
                    lvl_r <= sync2_r;
                    fire_r <= (sync2_r == lk.edge_rising);
                end else begin
                    deb_r <= deb_r + 6'h01;
                end
            end
        end
    end

    // Output pulse, length in ms ticks
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pulse_r <= 8'h00;
        end else if (lk.ce) begin
            if (lk.pulse_req) begin
                pulse_r <= lk.pulse_len;
            end else if (lk.tick && pulse_r != 8'h00) begin
                pulse_r <= pulse_r - 8'h01;
            end
        end
    end

    assign lk.fire = fire_r;
    assign trig_out_oe = (pulse_r != 8'h00);
endmodule

// >>> sim/lslt_switch.sv
// Trigger switch model wired to the trigger input pin
`timescale 1ns/10ps
module lslt_switch (
    input wire logic closed,
    output logic pin
);
    // Pull-up holds the line high while the switch is open
    assign pin = closed ? 1'b0 : 1'b1;
endmodule

// >>> sim/lslt_top_sva.sv
// Port assertions for the status lamp and trigger block
`timescale 1ns/10ps
module lslt_top_sva #(
    parameter int unsigned TICK_CYC = 100000
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic logger_mode,
    input wire logic usb_present,
    input wire logic can_powered,
    input wire logic disk_ready,
    input wire logic fw_cfg_err,
    input wire logic trig_pin_in,
    input wire logic trig_edge_rising,
    input wire logic pulse_req,
    input wire logic [7:0] pulse_len_ms,
    input wire logic trig_fire,
    input wire logic trig_out_o,
    input wire logic trig_out_oe,
    input wire logic log_start,
    input wire logic log_stop_close,
    input wire logic logging_on,
    input wire logic err_lamp_red
);
    int unsigned stable_cnt;
    logic pin_d;

    // Cycles since the trigger pin last changed
    always_ff @(posedge sys_clk) begin
        pin_d <= trig_pin_in;
        stable_cnt <= (trig_pin_in != pin_d) ? 32'h0 : stable_cnt + 1;
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n || !clk_en);

    a_out_level: assert property (trig_out_o == 1'b0)
        else $error("trigger output level not low");
    a_start_cause: assert property (log_start |-> logging_on
        && $past(logger_mode && can_powered && disk_ready && !usb_present))
        else $error("logging start without its conditions");
    a_stop_usb: assert property (log_stop_close |->
        !logging_on && $past(usb_present))
        else $error("log close without usb or still logging");
    a_fire_once: assert property (trig_fire |=> !trig_fire)
        else $error("trigger event longer than one cycle");
    a_fire_edge: assert property (trig_fire |->
        $past(trig_pin_in, 5) == trig_edge_rising)
        else $error("trigger fired on the wrong edge");
    a_deb_hold: assert property (trig_fire |->
        stable_cnt >= 29 * TICK_CYC)
        else $error("trigger fired before debounce time");
    a_pulse_start: assert property (pulse_req &&
        pulse_len_ms != 8'h00 |=> trig_out_oe)
        else $error("output pulse did not start");
    a_fw_red: assert property (fw_cfg_err |=> err_lamp_red)
        else $error("red lamp dark on firmware error");

    c_start: cover property (log_start);
    c_fire: cover property (trig_fire);
    c_pulse: cover property ($rose(trig_out_oe));
endmodule

bind lslt_top lslt_top_sva #(.TICK_CYC(TICK_CYC)) u_sva (
    .sys_clk, .reset_n, .clk_en, .logger_mode, .usb_present, .can_powered,
    .disk_ready, .fw_cfg_err, .trig_pin_in, .trig_edge_rising, .pulse_req,
    .pulse_len_ms, .trig_fire, .trig_out_o, .trig_out_oe, .log_start,
    .log_stop_close, .logging_on, .err_lamp_red
);

// >>> sim/lslt_top_tb.sv
// Self-checking bench for the status lamp and trigger block
`timescale 1ns/10ps
module lslt_top_tb;
    localparam int T = 2;
    logic sys_clk, reset_n, clk_en, logger_mode, err_frame_evt, log_armed;
    logic log_active, log_stopped, tool_comm, tool_disk_busy, disk_missing;
    logic usb_present, usb_no_comm, fw_cfg_err, can_powered, disk_ready;
    logic trig_edge_rising, pulse_req, sw_closed, trig_pin_in;
    logic [1:0] can_rx_evt, can_tx_evt, err_passive, bus_off;
    logic [2:0] major_err_code;
    logic [7:0] pulse_len_ms;
    logic trig_fire, trig_out_o, trig_out_oe, log_start, log_stop_close;
    logic logging_on, power_status_lamp, channel_one_lamp, channel_two_lamp;
    logic err_lamp_red, err_lamp_yellow;
    int err_total;
    int total_checks;
    int cyc;
    int cnt [7];

    // Block under test with a short millisecond tick
    lslt_top #(.TICK_CYC(T)) dut (
        .sys_clk, .reset_n, .clk_en, .logger_mode, .can_rx_evt, .can_tx_evt,
        .err_passive, .bus_off, .err_frame_evt, .major_err_code, .log_armed,
        .log_active, .log_stopped, .tool_comm, .tool_disk_busy, .disk_missing,
        .usb_present, .usb_no_comm, .fw_cfg_err, .can_powered, .disk_ready,
        .trig_edge_rising, .trig_pin_in, .pulse_req, .pulse_len_ms,
        .trig_fire, .trig_out_o, .trig_out_oe, .log_start, .log_stop_close,
        .logging_on, .power_status_lamp, .channel_one_lamp,
        .channel_two_lamp, .err_lamp_red, .err_lamp_yellow
    );

    // Trigger switch on the input pin
    lslt_switch u_sw (.closed(sw_closed), .pin(trig_pin_in));

    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            err_total++;
            complete_run();
        end
    end

    // Step n edges, then move just past the edge
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Status inputs idle
    task quiet();
        {logger_mode, err_frame_evt, log_armed, log_active, log_stopped} = '0;
        {tool_comm, tool_disk_busy, disk_missing, usb_present} = '0;
        {usb_no_comm, fw_cfg_err, can_powered, disk_ready, pulse_req} = '0;
        {can_rx_evt, can_tx_evt, err_passive, bus_off} = '0;
        major_err_code = 3'h0;
        pulse_len_ms = 8'h00;
    endtask

    // Count high cycles of each lamp output, trigger fire and pulse enable over n cycles
    task measure(input int n, input int s = 3);
        cnt = '{default: 0};
        tick(s);
        repeat (n) begin
            tick(1);
            cnt[0] += int'(power_status_lamp === 1'b1);
            cnt[1] += int'(channel_one_lamp === 1'b1);
            cnt[2] += int'(channel_two_lamp === 1'b1);
            cnt[3] += int'(err_lamp_red === 1'b1);
            cnt[4] += int'(err_lamp_yellow === 1'b1);
            cnt[5] += int'(trig_fire === 1'b1);
            cnt[6] += int'(trig_out_oe === 1'b1);
        end
    endtask

    // Compare one bit
    task check_bit(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask

    // Compare a cycle count, with some slack
    task check_cnt(input string name, input int exp, input int got,
        input int sl = 0);
        total_checks++;
        if (got < exp - sl || got > exp + sl) begin
            err_total++;
            $display("wrong value %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    // Verdict and end of run
    task complete_run();
        if (err_total == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Outputs idle in reset, then release
    task t_reset();
        reset_n = 1'b0;
        tick(16);
        check_bit("pulse_oe", 1'b0, trig_out_oe);
        check_bit("logging", 1'b0, logging_on);
        reset_n = 1'b1;
        tick(1);
    endtask

    // Session start, then orderly stop when usb appears
    task t_session();
        quiet();
        {logger_mode, can_powered, disk_ready} = 3'b111;
        tick(1);
        check_bit("start", 1'b1, log_start);
        check_bit("on", 1'b1, logging_on);
        tick(1);
        check_bit("start", 1'b0, log_start);
        usb_present = 1'b1;
        tick(1);
        check_bit("stop", 1'b1, log_stop_close);
        check_bit("on", 1'b0, logging_on);
        quiet();
        tick(2);
    endtask

    // Interface set: steady power and bus off, slow power while waiting
    task t_iface();
        quiet();
        usb_present = 1'b1;
        bus_off = 2'b10;
        measure(256 * T);
        check_cnt("power", 256 * T, cnt[0]);
        check_cnt("chan2", 256 * T, cnt[2]);
        usb_present = 1'b0;
        bus_off = 2'b00;
        measure(2048 * T);
        check_cnt("power", 1024 * T, cnt[0]);
    endtask

    // Logger set: traffic and error frame flashes
    task t_traffic();
        quiet();
        logger_mode = 1'b1;
        can_rx_evt = 2'b01;
        can_tx_evt = 2'b10;
        err_frame_evt = 1'b1;
        tick(1);
        {can_rx_evt, can_tx_evt, err_frame_evt} = '0;
        measure(60 * T, 0);
        check_cnt("chan1", 40 * T, cnt[1], T);
        check_cnt("chan2", 40 * T, cnt[2], T);
        check_cnt("yellow", 40 * T, cnt[4], T);
    endtask

    // Error passive and bus off channel patterns
    task t_chan_err();
        quiet();
        logger_mode = 1'b1;
        err_passive = 2'b01;
        measure(1024 * T);
        check_cnt("chan1", 512 * T, cnt[1]);
        check_cnt("red", 512 * T, cnt[3]);
        err_passive = 2'b00;
        bus_off = 2'b10;
        measure(4096 * T);
        check_cnt("chan2", 2048 * T, cnt[2]);
        check_cnt("red", 2048 * T, cnt[3]);
    endtask

    // Every major code while armed and error passive, undefined code too
    task t_major();
        int n;
        quiet();
        {logger_mode, log_armed, err_passive} = 4'b1101;
        for (int k = 1; k <= 6; k++) begin
            major_err_code = 3'(k);
            n = (k > 5) ? 5 : k;
            measure(4096 * T);
            check_cnt("yellow", n * 256 * T, cnt[4]);
            check_cnt("red", (16 - n) * 256 * T, cnt[3]);
        end
    endtask

    // Armed, active and stopped power patterns
    task t_logst();
        quiet();
        {logger_mode, log_armed} = 2'b11;
        measure(1024 * T);
        check_cnt("power", 922 * T, cnt[0]);
        {log_armed, log_active} = 2'b01;
        measure(128 * T);
        check_cnt("power", 64 * T, cnt[0]);
        {log_active, log_stopped} = 2'b01;
        measure(2048 * T);
        check_cnt("power", 1024 * T, cnt[0]);
    endtask

    // Tool, disk and usb patterns, firmware error
    task t_misc();
        quiet();
        tool_comm = 1'b1;
        measure(1024 * T);
        check_cnt("power", 256 * T, cnt[0]);
        check_cnt("chan2", 256 * T, cnt[2]);
        {tool_comm, tool_disk_busy, usb_present} = 3'b011;
        measure(512 * T);
        check_cnt("red", 256 * T, cnt[3]);
        quiet();
        {logger_mode, disk_missing} = 2'b11;
        measure(2048 * T);
        check_cnt("power", 1024 * T, cnt[0]);
        check_cnt("chan1", 1024 * T, cnt[1]);
        {disk_missing, usb_no_comm} = 2'b01;
        measure(4096 * T);
        check_cnt("power", 64 * T, cnt[0]);
        check_cnt("chan1", 0, cnt[1]);
        {usb_no_comm, fw_cfg_err} = 2'b01;
        measure(128 * T);
        check_cnt("power", 64 * T, cnt[0]);
        check_cnt("red", 128 * T, cnt[3]);
    endtask

    // Debounced trigger on either edge, short pulse dropped
    task t_trig();
        quiet();
        sw_closed = 1'b1;
        tick(20 * T);
        sw_closed = 1'b0;
        measure(40 * T, 0);
        check_cnt("fire", 0, cnt[5]);
        sw_closed = 1'b1;
        measure(40 * T, 0);
        check_cnt("fire", 1, cnt[5]);
        sw_closed = 1'b0;
        measure(40 * T, 0);
        check_cnt("fire", 0, cnt[5]);
        trig_edge_rising = 1'b1;
        sw_closed = 1'b1;
        measure(40 * T, 0);
        check_cnt("fire", 0, cnt[5]);
        sw_closed = 1'b0;
        measure(40 * T, 0);
        check_cnt("fire", 1, cnt[5]);
    endtask

    // Output pulse length, then a cancelling request
    task t_pulse();
        pulse_req = 1'b1;
        pulse_len_ms = 8'h05;
        tick(1);
        check_bit("pulse_on", 1'b1, trig_out_oe);
        check_bit("out_level", 1'b0, trig_out_o);
        pulse_req = 1'b0;
        measure(8 * T, 0);
        check_cnt("pulse", 4 * T + 1, cnt[6], T);
        check_bit("pulse_end", 1'b0, trig_out_oe);
        pulse_req = 1'b1;
        tick(1);
        pulse_len_ms = 8'h00;
        tick(1);
        pulse_req = 1'b0;
        tick(1);
        check_bit("cancel", 1'b0, trig_out_oe);
    endtask

    // Main sequence
    initial begin
        clk_en = 1'b1;
        trig_edge_rising = 1'b0;
        sw_closed = 1'b0;
        quiet();
        t_reset();
        t_session();
        t_iface();
        t_traffic();
        t_chan_err();
        t_major();
        t_logst();
        t_misc();
        t_trig();
        t_pulse();
        complete_run();
    end
endmodule
